/* core/cfg_bank_mem.sv */
// stored configuration banks with registered read data
`timescale 1ns/1ps
module cfg_bank_mem #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4,
    parameter int AW    = 2
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // write port
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    // read port
    input  wire logic             rd_en,
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];

    // no reset on the array: contents stand for non-volatile banks
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule : cfg_bank_mem

/* core/cfg_ref_select.sv */
// startup configuration loader and reference input selector
`timescale 1ns/1ps
module cfg_ref_select #(
    parameter int unsigned SETTLE_CYCLES   = cfgsel_pkg::SETTLE_CYCLES,
    parameter logic [31:0] SW_DEFAULT      = cfgsel_pkg::SW_DEFAULT_RESET,
    parameter logic        LOAD_AT_POWERUP = cfgsel_pkg::OTP_LOAD_RESET
) (
    // clock and reset
    input  wire logic                          CLK_SYS,
    input  wire logic                          RST_N,
    // ahb-lite slave
    input  wire logic                          HSEL,
    input  wire logic [31:0]                   HADDR,
    input  wire logic [1:0]                    HTRANS,
    input  wire logic                          HWRITE,
    input  wire logic [2:0]                    HSIZE,
    input  wire logic                          HREADY,
    input  wire logic [31:0]                   HWDATA,
    output logic      [31:0]                   HRDATA,
    output logic                               HREADYOUT,
    output logic                               HRESP,
    // straps and select pins
    input  wire logic                          MODE_STRAP_PIN,
    input  wire logic                          CONFIG_A,
    input  wire logic                          CONFIG_B,
    input  wire logic                          INPUT_CLOCK_SELECT_PIN,
    // configuration outputs
    output logic      [cfgsel_pkg::CFG_W-1:0]  ACTIVE_CONFIG,
    output logic                               CONFIG_VALID,
    output logic                               CONFIG_BUSY,
    output logic                               DIV_SYNC_RST,
    output logic                               SERIAL_OPEN,
    // reference and crystal
    output logic                               REF_SEL_DIFF,
    output logic                               REF_GATE,
    output logic      [cfgsel_pkg::TRIM_W-1:0] XIN_TRIM,
    output logic      [cfgsel_pkg::TRIM_W-1:0] XOUT_TRIM
);
    import cfgsel_pkg::*;

    localparam int RESUME_MAX = 2 * REF_GAP_CYCLES + 1;

    logic [2:0]          pin_meta;
    logic [2:0]          pin_sync;
    logic [IDX_W-1:0]    sel_idx;
    logic                input_clock_select_pin_s;
    logic                addr_phase;
    logic                addr_ok;
    logic                wr_pend;
    logic [7:0]          wr_off;
    logic [31:0]         rd_word;
    logic                wr_ctrl;
    logic                wr_ref;
    logic                wr_trim;
    logic                wr_cfg;
    logic                wr_bank;
    logic                wr_align;
    logic                prim;
    logic [SM_W-1:0]     sm;
    logic                mode_hw;
    load_state_type      state;
    load_state_type      next_state;
    logic [1:0]          boot_cnt;
    logic [23:0]         settle_cnt;
    logic [IDX_W-1:0]    tgt;
    logic [IDX_W-1:0]    next_tgt;
    logic                from_default;
    logic                next_from_default;
    logic [IDX_W-1:0]    loaded_idx;
    logic [CFG_W-1:0]    mem_rd;
    logic                manual;
    logic                want_ref;
    ref_state_type       ref_state;
    logic [3:0]          ref_cnt;
    logic                gap_done;

    // two-flop synchronisers on CONFIG_A, CONFIG_B and the clock select pin; the strap pin is sampled directly
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            pin_meta <= 3'h0;
            pin_sync <= 3'h0;
        end else begin
            pin_meta <= {INPUT_CLOCK_SELECT_PIN, CONFIG_B, CONFIG_A};
            pin_sync <= pin_meta;
        end
    end
    assign sel_idx  = pin_sync[1:0];
    assign input_clock_select_pin_s = pin_sync[2];

    // bus: zero wait state, always OKAY, word accesses only
    assign addr_phase = HSEL && HTRANS[1] && HREADY;
    assign addr_ok    = (HADDR[31:8] == 24'h000000);

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            wr_pend <= 1'b0;
            wr_off  <= 8'h00;
        end else begin
            wr_pend <= addr_phase && HWRITE && addr_ok;
            wr_off  <= HADDR[7:0];
        end
    end

    // serial writes are closed in hardware mode and during boot
    assign wr_ctrl  = wr_pend && SERIAL_OPEN && (wr_off == OFF_CTRL);
    assign wr_ref   = wr_pend && SERIAL_OPEN && (wr_off == OFF_REF);
    assign wr_trim  = wr_pend && SERIAL_OPEN && (wr_off == OFF_TRIM);
    assign wr_cfg   = wr_pend && SERIAL_OPEN && (wr_off == OFF_CFG);
    assign wr_bank  = wr_pend && SERIAL_OPEN && (wr_off >= OFF_BANK_FIRST)
                      && (wr_off <= OFF_BANK_LAST);
    assign wr_align = wr_ctrl && HWDATA[CTRL_ALIGN_BIT];

    always_comb begin
        rd_word = 32'h0000_0000;
        if (!addr_ok) begin
            rd_word = 32'h0000_0000;
        end else if (HADDR[7:0] == OFF_CTRL) begin
            rd_word[CTRL_LOAD_BIT] = LOAD_AT_POWERUP;
        end else if (HADDR[7:0] == OFF_REF) begin
            rd_word[REF_PRIM_BIT]        = prim;
            rd_word[REF_SM_LSB +: SM_W]  = sm;
        end else if (HADDR[7:0] == OFF_TRIM) begin
            rd_word[TRIM_XIN_LSB +: TRIM_W]  = XIN_TRIM;
            rd_word[TRIM_XOUT_LSB +: TRIM_W] = XOUT_TRIM;
        end else if (HADDR[7:0] == OFF_CFG) begin
            rd_word = ACTIVE_CONFIG;
        end else if (HADDR[7:0] == OFF_STATUS) begin
            rd_word[ST_SW_BIT]            = SERIAL_OPEN;
            rd_word[ST_IDX_LSB +: IDX_W]  = loaded_idx;
            rd_word[ST_BUSY_BIT]          = CONFIG_BUSY;
            rd_word[ST_REF_BIT]           = REF_SEL_DIFF;
            rd_word[ST_VALID_BIT]         = CONFIG_VALID;
            rd_word[ST_GATE_BIT]          = REF_GATE;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            HRDATA    <= 32'h0000_0000;
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
        end else if (addr_phase && !HWRITE) begin
            HRDATA <= rd_word;
        end
    end

    // software-owned control registers
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            prim      <= PRIM_RESET;
            sm        <= SM_RESET;
            XIN_TRIM  <= TRIM_RESET;
            XOUT_TRIM <= TRIM_RESET;
        end else begin
            if (wr_ref) begin
                prim <= HWDATA[REF_PRIM_BIT];
                sm   <= HWDATA[REF_SM_LSB +: SM_W];
            end
            if (wr_trim) begin
                // separate codes per pin; equal codes are the usual choice
                XIN_TRIM  <= HWDATA[TRIM_XIN_LSB +: TRIM_W];
                XOUT_TRIM <= HWDATA[TRIM_XOUT_LSB +: TRIM_W];
            end
        end
    end

    cfg_bank_mem #(
        .WIDTH (CFG_W),
        .DEPTH (CFG_COUNT),
        .AW    (IDX_W)
    ) cfg_bank_mem_inst (
        .clk     (CLK_SYS),
        .rst_n   (RST_N),
        .wr_en   (wr_bank),
        .wr_addr (wr_off[3:2]),
        .wr_data (HWDATA),
        .rd_en   (state == ST_READ),
        .rd_addr (tgt),
        .rd_data (mem_rd)
    );

    // load sequencer
    always_comb begin
        next_state        = state;
        next_tgt          = tgt;
        next_from_default = from_default;
        case (state)
            ST_BOOT: begin
                if (boot_cnt == 2'(BOOT_CYCLES - 1)) begin
                    if (MODE_STRAP_PIN) begin
                        next_state = ST_READ;
                        next_tgt   = sel_idx;
                    end else if (LOAD_AT_POWERUP) begin
                        next_state        = ST_APPLY;
                        next_from_default = 1'b1;
                    end else begin
                        next_state = ST_READ;
                        next_tgt   = '0;
                    end
                end
            end
            ST_READ: begin
                next_state = ST_APPLY;
            end
            ST_APPLY: begin
                next_state = ST_SETTLE;
            end
            ST_SETTLE: begin
                if (settle_cnt == 24'(SETTLE_CYCLES - 1)) begin
                    next_state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                // pin changes during settling are picked up here afterwards
                if (mode_hw && (sel_idx != loaded_idx)) begin
                    next_state        = ST_READ;
                    next_tgt          = sel_idx;
                    next_from_default = 1'b0;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            state        <= ST_BOOT;
            tgt          <= '0;
            from_default <= 1'b0;
            boot_cnt     <= 2'h0;
            settle_cnt   <= 24'h000000;
        end else begin
            state        <= next_state;
            tgt          <= next_tgt;
            from_default <= next_from_default;
            if (state == ST_BOOT) begin
                boot_cnt <= boot_cnt + 2'h1;
            end
            settle_cnt <= (state == ST_SETTLE) ? settle_cnt + 24'h1 : 24'h0;
        end
    end

    // strap captured once, at the end of boot, never again
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            SERIAL_OPEN <= 1'b0;
            mode_hw     <= 1'b0;
        end else if (state == ST_BOOT && next_state != ST_BOOT) begin
            SERIAL_OPEN <= !MODE_STRAP_PIN;
            mode_hw     <= MODE_STRAP_PIN;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            ACTIVE_CONFIG <= '0;
            CONFIG_VALID  <= 1'b0;
            loaded_idx    <= '0;
        end else if (state == ST_APPLY) begin
            ACTIVE_CONFIG <= from_default ? SW_DEFAULT : mem_rd;
            CONFIG_VALID  <= 1'b1;
            loaded_idx    <= tgt;
        end else if (wr_cfg) begin
            ACTIVE_CONFIG <= HWDATA;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            CONFIG_BUSY  <= 1'b1;
            DIV_SYNC_RST <= 1'b0;
        end else begin
            CONFIG_BUSY  <= (next_state != ST_IDLE);
            DIV_SYNC_RST <= ((state == ST_APPLY) && mode_hw) || wr_align;
        end
    end

    // reference selection with break-before-make gating
    assign manual   = !sm[1];
    assign want_ref = manual ? (prim ^ input_clock_select_pin_s) : REF_SEL_DIFF;
    assign gap_done = (ref_cnt == 4'(REF_GAP_CYCLES - 1));

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            ref_state    <= REF_RUN;
            ref_cnt      <= 4'h0;
            REF_SEL_DIFF <= 1'b0;
            REF_GATE     <= 1'b1;
        end else begin
            case (ref_state)
                REF_RUN: begin
                    ref_cnt <= 4'h0;
                    if (want_ref != REF_SEL_DIFF) begin
                        REF_GATE  <= 1'b0;
                        ref_state <= REF_OFF;
                    end
                end
                REF_OFF: begin
                    ref_cnt <= gap_done ? 4'h0 : ref_cnt + 4'h1;
                    if (gap_done) begin
                        REF_SEL_DIFF <= want_ref;
                        ref_state    <= REF_ON;
                    end
                end
                REF_ON: begin
                    ref_cnt <= ref_cnt + 4'h1;
                    if (gap_done) begin
                        REF_GATE  <= 1'b1;
                        ref_state <= REF_RUN;
                    end
                end
                default: begin
                    ref_state <= REF_RUN;
                end
            endcase
        end
    end

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);

    a_mode_frozen: assert property (
        (state != ST_BOOT) |=> $stable(SERIAL_OPEN) && $stable(mode_hw))
        else $error("mode changed after boot");

    a_sw_cfg_write: assert property (
        (wr_cfg && state != ST_APPLY) |=> ACTIVE_CONFIG == $past(HWDATA))
        else $error("software config write lost");

    a_hw_closed: assert property (
        (wr_pend && mode_hw && state != ST_APPLY) |=> $stable(ACTIVE_CONFIG))
        else $error("write accepted in hardware mode");

    a_hw_index: assert property (
        (state == ST_READ && mode_hw) |-> ##2 loaded_idx == $past(tgt, 2))
        else $error("wrong bank loaded");

    a_boot_default: assert property (
        (state == ST_APPLY && from_default) |=> ACTIVE_CONFIG == SW_DEFAULT)
        else $error("default not applied");

    a_sw_bank0: assert property (
        (state == ST_READ && SERIAL_OPEN) |-> tgt == '0)
        else $error("software mode loaded nonzero bank");

    a_sel_reload: assert property (
        (state == ST_IDLE && mode_hw && sel_idx != loaded_idx)
        |-> ##[1:3] (state == ST_APPLY))
        else $error("select change not reloaded");

    a_settle_busy: assert property (
        (state == ST_APPLY) |=> CONFIG_BUSY [*8])
        else $error("busy dropped early");

    a_ref_follow: assert property (
        (ref_state == REF_RUN && want_ref != REF_SEL_DIFF)
        |=> !REF_GATE ##[1:RESUME_MAX] REF_GATE)
        else $error("reference switch stalled");

    a_prim_reset: assert property (
        (state == ST_BOOT) |-> !prim && !REF_SEL_DIFF)
        else $error("primary source not reset");

    a_auto_hold: assert property (
        (sm[1] && ref_state == REF_RUN) |=> ref_state == REF_RUN)
        else $error("switch without manual mode");

    a_ref_clean: assert property (
        !$stable(REF_SEL_DIFF) |-> !REF_GATE && !$past(REF_GATE))
        else $error("reference changed while gated on");

    a_trim_write: assert property (
        wr_trim |=> XIN_TRIM == $past(HWDATA[TRIM_XIN_LSB +: TRIM_W]))
        else $error("trim code not stored");

    a_sync_pulse: assert property (
        (state == ST_APPLY && mode_hw) |=> DIV_SYNC_RST)
        else $error("missing divider sync");

    c_hw_reload: cover property (
        mode_hw && state == ST_IDLE ##1 state == ST_READ);
    c_ref_switch: cover property ($rose(REF_SEL_DIFF));
    c_sw_write: cover property (wr_cfg);
    c_align: cover property (wr_align);
endmodule : cfg_ref_select

/* shared/cfgsel_pkg.sv */
// constants and types for startup configuration and reference selection
package cfgsel_pkg;
    // sizes
    localparam int          CFG_W            = 32;
    localparam int          CFG_COUNT        = 4;
    localparam int          IDX_W            = 2;
    localparam int          TRIM_W           = 6;
    localparam int          SM_W             = 2;
    // timing
    localparam int          CLK_FREQ_MHZ     = 25;
    localparam int          SETTLE_TIME_US   = 1000;
    localparam int          SETTLE_CYCLES    = SETTLE_TIME_US * CLK_FREQ_MHZ;
    localparam int          BOOT_CYCLES      = 3;
    localparam int          REF_GAP_CYCLES   = 4;
    // register byte offsets
    localparam logic [7:0]  OFF_CTRL         = 8'h00;
    localparam logic [7:0]  OFF_REF          = 8'h04;
    localparam logic [7:0]  OFF_TRIM         = 8'h08;
    localparam logic [7:0]  OFF_CFG          = 8'h0C;
    localparam logic [7:0]  OFF_STATUS       = 8'h10;
    localparam logic [7:0]  OFF_BANK_FIRST   = 8'h20;
    localparam logic [7:0]  OFF_BANK_LAST    = 8'h2C;
    // field positions
    localparam int          CTRL_ALIGN_BIT   = 0;
    localparam int          CTRL_LOAD_BIT    = 7;
    localparam int          REF_PRIM_BIT     = 1;
    localparam int          REF_SM_LSB       = 2;
    localparam int          TRIM_XIN_LSB     = 0;
    localparam int          TRIM_XOUT_LSB    = 8;
    localparam int          ST_SW_BIT        = 0;
    localparam int          ST_IDX_LSB       = 1;
    localparam int          ST_BUSY_BIT      = 3;
    localparam int          ST_REF_BIT       = 4;
    localparam int          ST_VALID_BIT     = 5;
    localparam int          ST_GATE_BIT      = 6;
    // reset values
    localparam logic        PRIM_RESET       = 1'b0;
    localparam logic [1:0]  SM_RESET         = 2'h0;
    localparam logic [5:0]  TRIM_RESET       = 6'h00;
    localparam logic        OTP_LOAD_RESET   = 1'b0;
    localparam logic [31:0] SW_DEFAULT_RESET = 32'h0000_0000;
    // state machines
    typedef enum logic [2:0] {
        ST_BOOT, ST_READ, ST_APPLY, ST_SETTLE, ST_IDLE
    } load_state_type;
    typedef enum logic [1:0] {
        REF_RUN, REF_OFF, REF_ON
    } ref_state_type;
endpackage : cfgsel_pkg

/* sim/sel_host.sv */
// host gpio model driving the select pins and the clock select pin
`timescale 1ns/1ps
module sel_host #(
    parameter int GAP = 40
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // requested levels
    input  wire logic [1:0] want_sel,
    input  wire logic       want_clk,
    // pins
    output logic            config_a,
    output logic            config_b,
    output logic            clk_sel
);
    int cnt;
    // gap scaled down from the lockout and settle times
    always @(posedge clk or negedge rst_n) begin
        clk_sel <= want_clk;
        if (!rst_n) begin
            config_a <= want_sel[0];
            config_b <= want_sel[1];
            cnt      <= 0;
        end else if (cnt < GAP) begin
            cnt <= cnt + 1;
        end else if (config_a != want_sel[0]) begin
            config_a <= want_sel[0];
            cnt      <= 0;
        end else if (config_b != want_sel[1]) begin
            config_b <= want_sel[1];
            cnt      <= 0;
        end
    end
endmodule : sel_host

/* sim/tb_cfg_ref_select.sv */
// self-checking bench for configuration and reference selection
`timescale 1ns/1ps
module tb_cfg_ref_select;
    import cfgsel_pkg::*;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] dflt_config;
    // power-up default word of the second instance; value is arbitrary
    localparam logic [31:0] DFLT_WORD = 32'h5AFE_0001;
    logic        strap_pin = 1'b0;
    logic [1:0]  want_sel = 2'h0;
    logic        want_clk = 1'b0;
    logic        cfg_a, cfg_b, clk_sel;
    logic [31:0] active_config;
    logic        config_valid, config_busy, div_sync_rst, serial_open;
    logic        ref_sel_diff, ref_gate, prev_sel;
    logic [5:0]  xin_trim, xout_trim;
    int          errors = 0;
    int          checks = 0;

    always #20 clk_sys = ~clk_sys;

    cfg_ref_select #(.SETTLE_CYCLES(16)) cfg_ref_select_inst (
        .CLK_SYS(clk_sys), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HREADY(hreadyout),
        .HWDATA(hwdata), .HRDATA(hrdata), .HREADYOUT(hreadyout),
        .HRESP(hresp),
        .MODE_STRAP_PIN(strap_pin), .CONFIG_A(cfg_a), .CONFIG_B(cfg_b),
        .INPUT_CLOCK_SELECT_PIN(clk_sel), .ACTIVE_CONFIG(active_config),
        .CONFIG_VALID(config_valid), .CONFIG_BUSY(config_busy),
        .DIV_SYNC_RST(div_sync_rst), .SERIAL_OPEN(serial_open),
        .REF_SEL_DIFF(ref_sel_diff), .REF_GATE(ref_gate),
        .XIN_TRIM(xin_trim), .XOUT_TRIM(xout_trim));

    // second instance with the load-at-powerup bit set, bus idle
    cfg_ref_select #(.SETTLE_CYCLES(16), .SW_DEFAULT(DFLT_WORD),
        .LOAD_AT_POWERUP(1'b1)) dflt_cfg_ref_select_inst (
        .CLK_SYS(clk_sys), .RST_N(rst_n), .HSEL(1'b0), .HADDR(32'h0),
        .HTRANS(2'h0), .HWRITE(1'b0), .HSIZE(3'h2), .HREADY(1'b1),
        .HWDATA(32'h0), .HRDATA(), .HREADYOUT(), .HRESP(),
        .MODE_STRAP_PIN(strap_pin), .CONFIG_A(cfg_a), .CONFIG_B(cfg_b),
        .INPUT_CLOCK_SELECT_PIN(clk_sel), .ACTIVE_CONFIG(dflt_config),
        .CONFIG_VALID(), .CONFIG_BUSY(), .DIV_SYNC_RST(),
        .SERIAL_OPEN(), .REF_SEL_DIFF(), .REF_GATE(), .XIN_TRIM(),
        .XOUT_TRIM());

    sel_host sel_host_inst (
        .clk(clk_sys), .rst_n(rst_n), .want_sel(want_sel),
        .want_clk(want_clk), .config_a(cfg_a), .config_b(cfg_b),
        .clk_sel(clk_sel));

    // a source flip while the gate is open would reach the outputs
    always @(negedge clk_sys) begin
        if (rst_n && ref_gate === 1'b1 && ref_sel_diff !== prev_sel) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, ref_sel_diff,
                     prev_sel);
        end
        prev_sel <= ref_sel_diff;
    end

    function automatic logic [31:0] bank(input int i);
        return 32'hC0DE_0000 | 32'(i);
    endfunction : bank

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : cyc

    task automatic ahb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        int n;
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        n = 0;
        do begin @(posedge clk_sys); n++; end
        while (hreadyout !== 1'b1 && n < 50);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do begin @(posedge clk_sys); n++; end
        while (hreadyout !== 1'b1 && n < 100);
        rd = hrdata;
        #1;
    endtask : ahb

    task automatic rst(input logic strap);
        @(posedge clk_sys);
        rst_n <= 1'b0;
        strap_pin <= strap;
        cyc(1);
        chk(ref_sel_diff, 0);
        chk(serial_open, 0);
        @(posedge clk_sys);
        rst_n <= 1'b1;
    endtask : rst

    task automatic t_sw;
        logic [31:0] r;
        rst(1'b0);
        cyc(5);
        chk(serial_open, 1);
        chk(dflt_config, DFLT_WORD);
        ahb(1'b0, OFF_REF, 32'h0, r);
        chk(r, 32'h0);
        for (int i = 0; i < 4; i++) begin
            ahb(1'b1, OFF_BANK_FIRST + 8'(4 * i), bank(i), r);
        end
        ahb(1'b1, OFF_CFG, 32'h1234_5678, r);
        ahb(1'b0, OFF_CFG, 32'h0, r);
        chk(r, 32'h1234_5678);
        chk(active_config, 32'h1234_5678);
        $display("test software mode done");
    endtask : t_sw

    task automatic t_hw;
        logic [31:0] r;
        int n, pulses;
        want_sel <= 2'h2;
        rst(1'b1);
        n = 0;
        while (config_valid !== 1'b1 && n < 20) begin cyc(1); n++; end
        chk(active_config, bank(2));
        chk(serial_open, 0);
        ahb(1'b1, OFF_CFG, 32'hDEAD_BEEF, r);
        cyc(2);
        chk(active_config, bank(2));
        want_sel <= 2'h1;
        pulses = 0;
        while (active_config !== bank(1) && n < 400) begin
            cyc(1);
            n++;
            if (div_sync_rst === 1'b1) pulses++;
        end
        chk(active_config, bank(1));
        chk(32'(pulses), 32'h2);
        chk(config_busy, 1);
        $display("test hardware select done");
    endtask : t_hw

    task automatic t_ref;
        logic [31:0] r;
        want_sel <= 2'h0;
        rst(1'b0);
        cyc(8);
        chk(active_config, bank(0));
        for (int p = 0; p < 2; p++) begin
            for (int c = 0; c < 2; c++) begin
                ahb(1'b1, OFF_REF, {30'h0, p[0], 1'b0}, r);
                want_clk <= c[0];
                cyc(16);
                chk(ref_sel_diff, 32'(p ^ c));
            end
        end
        ahb(1'b1, OFF_REF, 32'h0000_000A, r);
        want_clk <= 1'b0;
        cyc(16);
        chk(ref_sel_diff, 0);
        chk(ref_gate, 1);
        $display("test reference select done");
    endtask : t_ref

    task automatic t_trim;
        logic [31:0] r;
        ahb(1'b1, OFF_TRIM, 32'h0000_2A3F, r);
        chk(xin_trim, 6'h3F);
        chk(xout_trim, 6'h2A);
        ahb(1'b0, OFF_TRIM, 32'h0, r);
        chk(r, 32'h0000_2A3F);
        ahb(1'b1, OFF_TRIM, 32'h0000_1414, r);
        chk(xin_trim, 6'h14);
        chk(xout_trim, 6'h14);
        ahb(1'b1, OFF_CTRL, 32'h0000_0001, r);
        chk(div_sync_rst, 1);
        chk(hresp, 0);
        ahb(1'b0, OFF_CTRL, 32'h0, r);
        chk(r, 32'(OTP_LOAD_RESET) << CTRL_LOAD_BIT);
        ahb(1'b0, OFF_STATUS, 32'h0, r);
        chk(r, 32'h0000_0061);
        ahb(1'b0, 8'hF0, 32'h0, r);
        chk(r, 32'h0);
        $display("test trim done");
    endtask : t_trim

    task automatic results;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results

    initial begin
        #(40 * 5000);
        errors++;
        results();
    end

    initial begin
        t_sw();
        t_hw();
        t_ref();
        t_trim();
        results();
    end
endmodule : tb_cfg_ref_select
